//--- hdl/arf_pkg.sv
// Package of constants and types for the address register file core.
package arf_pkg;

  // Register file geometry.
  localparam int NREG  = 8;  // Number of address registers.
  localparam int DW    = 32; // Width of each address register.
  localparam int DEPTH = 8;  // Write-back schedule slots.

  // Arrival latencies, in clock periods from issue to write-back.
  localparam logic [2:0] LAT_ENTRY = 3'h1; // Immediate and transfers.
  localparam logic [2:0] LAT_ADD   = 3'h2; // Add and subtract.
  localparam logic [2:0] LAT_MUL   = 3'h4; // Multiply.
  localparam logic [2:0] LAT_BITC  = 3'h3; // Bit counts.
  localparam logic [2:0] LAT_CHAN  = 3'h2; // Channel queries.
  localparam logic [2:0] LAT_LOAD  = 3'h6; // Memory loads.

  // Exponent given to an unnormalized floating-point transfer.
  localparam logic [14:0] FP_EXP_BIAS = 15'h4000; // Exponent bias.
  localparam logic [14:0] FP_EXP_UNRM = 15'h4030; // Bias plus 48.

  // Register bus byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00; // Bit 0 monitor mode.
  localparam logic [7:0] OFF_DBO    = 8'h04; // Data base offset.
  localparam logic [7:0] OFF_XA     = 8'h08; // Exchange address.
  localparam logic [7:0] OFF_CLN    = 8'h0c; // Cluster number.
  localparam logic [7:0] OFF_VL     = 8'h10; // Vector length.
  localparam logic [7:0] OFF_STATUS = 8'h14; // Flags and reservations.
  localparam logic [7:0] OFF_AREG   = 8'h20; // A0 to A7, one word each.

  // Field positions in the status word.
  localparam int ST_XA_REFUSED = 0;  // Sticky, write one to clear.
  localparam int ST_UNSUPP     = 1;  // Sticky, write one to clear.
  localparam int ST_RSV_LO     = 8;  // Live reservations, 8 bits.
  localparam int ST_BUSY       = 16; // Any write-back pending.

  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Source of the data that a scheduled write-back delivers.
  typedef enum logic [1:0] {
    SRC_NOW = 2'b00, // Value computed at issue.
    SRC_MEM = 2'b01, // Memory return data at arrival.
    SRC_CHA = 2'b10, // Channel current address at arrival.
    SRC_CHE = 2'b11  // Channel error flag at arrival.
  } arf_src_t;

  // One instruction as presented by the issue logic.
  typedef struct packed {
    logic [3:0]  g;   // Opcode digits.
    logic [2:0]  h;   // h designator.
    logic [2:0]  i;   // i designator.
    logic [2:0]  j;   // j designator.
    logic [2:0]  k;   // k designator.
    logic [31:0] imm; // Immediate or jump target.
  } arf_instr_t;

  // One slot of the write-back schedule.
  typedef struct packed {
    logic        vld;  // Slot booked.
    logic [2:0]  dst;  // Destination register.
    arf_src_t    src;  // Where the data comes from.
    logic [31:0] data; // Data computed at issue.
  } arf_slot_t;

  // Classic Wishbone request from the bus master.
  typedef struct packed {
    logic        cyc; // Cycle.
    logic        stb; // Strobe.
    logic        we;  // Write enable.
    logic [3:0]  sel; // Byte lanes.
    logic [7:0]  adr; // Byte address.
    logic [31:0] dat; // Write data.
  } arf_wb_req_t;

  // Memory request toward central memory.
  typedef struct packed {
    logic        req;   // One-cycle request pulse.
    logic        we;    // High for a store.
    logic [31:0] addr;  // Absolute address.
    logic [31:0] wdata; // Store data.
  } arf_mem_req_t;

  // Transfer of an address value into a scalar register.
  typedef struct packed {
    logic        vld;  // One-cycle pulse.
    logic [2:0]  idx;  // Scalar register number.
    logic [63:0] data; // Scalar value.
  } arf_sres_t;

  // Jump and interprocessor interrupt outputs.
  typedef struct packed {
    logic        taken;  // One-cycle pulse.
    logic [31:0] target; // Jump target.
  } arf_jump_t;

  typedef struct packed {
    logic        req; // One-cycle pulse.
    logic [31:0] cpu; // Target CPU number.
  } arf_ipi_t;

endpackage

//--- hdl/arf_core.sv
// Address register file with issue checks, write-back booking and decode.
`timescale 1ns/10ps

module arf_core
  import arf_pkg::*;
(
  input  wire logic         clk_sys_i,      // System clock, 100 MHz.
  input  wire logic         rst_i,          // Asynchronous reset.
  input  wire arf_wb_req_t  wb_i,           // Wishbone request.
  output logic              wb_ack_o,       // Wishbone acknowledge.
  output logic [31:0]       wb_dat_o,       // Wishbone read data.
  input  wire logic         issue_valid_i,  // Instruction offered.
  input  wire arf_instr_t   issue_instr_i,  // Instruction fields.
  input  wire logic [63:0]  issue_s_op_i,   // Value of Sj.
  output logic              issue_ack_o,    // Instruction issued.
  output arf_mem_req_t      mem_o,          // Memory request.
  input  wire logic [31:0]  mem_rdata_i,    // Load data at arrival.
  input  wire logic [31:0]  chan_irq_num_i, // Top interrupting channel.
  input  wire logic [31:0]  chan_addr_i,    // Address of chan_sel_o.
  input  wire logic         chan_err_i,     // Error of chan_sel_o.
  output logic [31:0]       chan_sel_o,     // Channel being queried.
  output arf_sres_t         s_result_o,     // Transfer into Si.
  output arf_jump_t         jump_o,         // Conditional jump.
  output arf_ipi_t          ipi_o,          // Interprocessor interrupt.
  output logic [31:0]       xa_o,           // Exchange address.
  output logic [31:0]       cln_o,          // Cluster number.
  output logic [31:0]       vl_o            // Vector length.
);

  // Whole state of the block in one packed record.
  typedef struct packed {
    logic [NREG-1:0][DW-1:0] areg;     // Address registers.
    logic [NREG-1:0]         rsv;      // Register reservations.
    arf_slot_t [DEPTH-1:0]   pipe;     // Write-back schedule.
    logic                    issue_ack;
    arf_mem_req_t            mem;
    logic [31:0]             chan_sel;
    arf_sres_t               sres;
    arf_jump_t               jump;
    arf_ipi_t                ipi;
    logic [31:0]             xa;
    logic [31:0]             cluster_number_register;
    logic [31:0]             vl;
    logic                    monitor;  // Monitor mode control bit.
    logic [31:0]             dbo;      // Data base offset.
    logic                    xa_refused;
    logic                    unsupp;
    logic                    wb_ack;
    logic [31:0]             wb_dat;
  } arf_state_t;

  arf_state_t st;      // Registered state.
  arf_state_t next_st; // Next state.

  // Counts the ones of a 64-bit word.
  function automatic logic [31:0] pop64(input logic [63:0] v);
    logic [31:0] c;
    c = '0;
    for (int n = 0; n < 64; n++) begin
      c = c + {31'h0, v[n]};
    end
    return c;
  endfunction

  // Counts the zeros above the highest one of a 64-bit word.
  function automatic logic [31:0] lzc64(input logic [63:0] v);
    logic [31:0] c;
    logic        hit;
    c   = '0;
    hit = 1'b0;
    for (int n = 63; n >= 0; n--) begin
      if (v[n]) begin
        hit = 1'b1;
      end else if (!hit) begin
        c = c + 32'h1;
      end
    end
    return c;
  endfunction

  // Merges write data into a word by Wishbone byte lanes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Next-state logic: write-back, issue, decode and the register bus.
  always_comb begin : next_state
    arf_instr_t  ins;
    logic [31:0] ah;
    logic [31:0] aj;
    logic [31:0] ak;
    logic [31:0] ai;
    logic [63:0] prod;
    logic [31:0] res;
    logic [31:0] wval;
    logic [2:0]  lat;
    arf_src_t    src;
    logic        wr;
    logic        use_h;
    logic        use_j;
    logic        use_k;
    logic        use_i;
    logic        use_a0;
    logic        hold;
    logic        take;
    logic [7:0]  woff;
    ins    = issue_instr_i;
    res    = '0;
    wval   = '0;
    lat    = LAT_ENTRY;
    src    = SRC_NOW;
    wr     = 1'b0;
    use_h  = 1'b0;
    use_j  = 1'b0;
    use_k  = 1'b0;
    use_i  = 1'b0;
    use_a0 = 1'b0;
    woff   = '0;

    // Constants replace register zero on h, j and k only.
    ah   = (ins.h == 3'h0) ? 32'h0 : st.areg[ins.h];
    aj   = (ins.j == 3'h0) ? 32'h0 : st.areg[ins.j];
    ak   = (ins.k == 3'h0) ? 32'h1 : st.areg[ins.k];
    ai   = st.areg[ins.i];
    prod = aj * ak;

    // Pulses last one cycle unless renewed below.
    next_st           = st;
    next_st.issue_ack = 1'b0;
    next_st.mem.req   = 1'b0;
    next_st.sres.vld  = 1'b0;
    next_st.jump.taken = 1'b0;
    next_st.ipi.req   = 1'b0;
    next_st.wb_ack    = 1'b0;

    // The schedule advances one slot per clock period.
    for (int n = 0; n < DEPTH - 1; n++) begin
      next_st.pipe[n] = st.pipe[n+1];
    end
    next_st.pipe[DEPTH-1] = '0;

    // Slot zero is the only write into the file this period.
    if (st.pipe[0].vld) begin
      case (st.pipe[0].src)
        SRC_MEM: wval = mem_rdata_i;
        SRC_CHA: wval = chan_addr_i;
        SRC_CHE: wval = {31'h0, chan_err_i};
        default: wval = st.pipe[0].data;
      endcase
      next_st.areg[st.pipe[0].dst] = wval;
      next_st.rsv[st.pipe[0].dst]  = 1'b0;
    end

    // Decode: which operands are read and what result is formed.
    case (ins.g)
      4'h0: begin
        // Interregister transfers out of the file.
        use_j = (ins.h == 3'h1);
        use_k = (ins.h == 3'h2);
      end
      4'h1: begin
        // Conditional jumps test register zero implicitly.
        use_a0 = (ins.h <= 3'h3);
      end
      4'h2: begin
        case (ins.h)
          3'h0: begin
            wr  = 1'b1;
            res = ins.imm;
          end
          3'h1: begin
            wr  = 1'b1;
            res = ~ins.imm;
          end
          3'h2: begin
            wr  = 1'b1;
            res = {26'h0, ins.j, ins.k};
          end
          3'h3: begin
            wr  = (ins.k <= 3'h1);
            res = (ins.k == 3'h0) ? issue_s_op_i[31:0]
                                  : st.vl;
          end
          3'h6: begin
            wr  = (ins.k <= 3'h1);
            lat = LAT_BITC;
            res = pop64(issue_s_op_i);
            if (ins.k == 3'h1) begin
              res = {31'h0, ^issue_s_op_i};
            end
          end
          3'h7: begin
            wr  = (ins.k == 3'h0);
            lat = LAT_BITC;
            res = lzc64(issue_s_op_i);
          end
          default: wr = 1'b0;
        endcase
      end
      4'h3: begin
        case (ins.h)
          3'h0: begin
            wr    = 1'b1;
            use_j = 1'b1;
            use_k = 1'b1;
            lat   = LAT_ADD;
            res   = aj + ak;
          end
          3'h1: begin
            wr    = 1'b1;
            use_j = 1'b1;
            use_k = 1'b1;
            lat   = LAT_ADD;
            res   = aj - ak;
          end
          3'h2: begin
            wr    = 1'b1;
            use_j = 1'b1;
            use_k = 1'b1;
            lat   = LAT_MUL;
            res   = prod[31:0];
          end
          3'h3: begin
            wr    = (ins.k <= 3'h1);
            use_j = 1'b1;
            lat   = LAT_CHAN;
            if (ins.j == 3'h0 && ins.k == 3'h0) begin
              res = chan_irq_num_i;
            end else if (ins.k == 3'h0) begin
              src = SRC_CHA;
            end else begin
              src = SRC_CHE;
            end
          end
          default: wr = 1'b0;
        endcase
      end
      4'h7: begin
        use_k = (ins.h == 3'h1);
      end
      4'h8: begin
        wr    = 1'b1;
        use_h = 1'b1;
        lat   = LAT_LOAD;
        src   = SRC_MEM;
      end
      4'h9: begin
        use_h = 1'b1;
        use_i = 1'b1;
      end
      default: wr = 1'b0;
    endcase

    // Hold on any reserved operand other than a substituted zero.
    hold = (use_h && ins.h != 3'h0 && st.rsv[ins.h])
         | (use_j && ins.j != 3'h0 && st.rsv[ins.j])
         | (use_k && ins.k != 3'h0 && st.rsv[ins.k])
         | (use_i && st.rsv[ins.i])
         | (use_a0 && st.rsv[0])
         | (wr && st.rsv[ins.i])
         | (wr && st.pipe[lat].vld);
    take = issue_valid_i && !st.issue_ack && !hold;

    // Issue: book the arrival slot and carry out side effects.
    if (take) begin
      next_st.issue_ack = 1'b1;
      if (wr) begin
        next_st.rsv[ins.i]       = 1'b1;
        next_st.pipe[lat - 3'h1] = '{vld:  1'b1,
                                     dst:  ins.i,
                                     src:  src,
                                     data: res};
      end
      case (ins.g)
        4'h0: begin
          if (ins.h == 3'h1 && ins.i == 3'h3 && ins.k == 3'h0) begin
            if (st.monitor) begin
              next_st.xa = aj;
            end else begin
              next_st.xa_refused = 1'b1;
            end
          end else if (ins.h == 3'h1 && ins.i == 3'h4 &&
                       ins.k == 3'h3) begin
            next_st.cluster_number_register = aj;
          end else if (ins.h == 3'h1 && ins.i == 3'h4 &&
                       ins.k == 3'h1) begin
            next_st.ipi.req = 1'b1;
            next_st.ipi.cpu = aj;
          end else if (ins.h == 3'h2 && ins.i == 3'h0 &&
                       ins.j == 3'h0) begin
            next_st.vl = ak;
          end else begin
            next_st.unsupp = 1'b1;
          end
        end
        4'h1: begin
          next_st.jump.target = ins.imm;
          case (ins.h)
            3'h0: next_st.jump.taken = (st.areg[0] == 32'h0);
            3'h1: next_st.jump.taken = (st.areg[0] != 32'h0);
            3'h2: next_st.jump.taken = !st.areg[0][31];
            3'h3: next_st.jump.taken = st.areg[0][31];
            default: next_st.unsupp = 1'b1;
          endcase
        end
        4'h2: begin
          if (!wr) begin
            next_st.unsupp = 1'b1;
          end
        end
        4'h3: begin
          if (ins.h == 3'h3) begin
            next_st.chan_sel = aj;
          end
          if (!wr) begin
            next_st.unsupp = 1'b1;
          end
        end
        4'h7: begin
          if (ins.h == 3'h1 && ins.j <= 3'h2) begin
            next_st.sres.vld = 1'b1;
            next_st.sres.idx = ins.i;
            case (ins.j)
              3'h0: next_st.sres.data = {32'h0, ak};
              3'h1: next_st.sres.data = {{32{ak[31]}}, ak};
              default: next_st.sres.data = {1'b0, FP_EXP_UNRM,
                                            16'h0, ak};
            endcase
          end else begin
            next_st.unsupp = 1'b1;
          end
        end
        4'h8, 4'h9: begin
          // Loads and stores leave with the base offset applied.
          next_st.mem.req   = 1'b1;
          next_st.mem.we    = (ins.g == 4'h9);
          next_st.mem.addr  = st.dbo + ah + ins.imm;
          next_st.mem.wdata = ai;
        end
        default: next_st.unsupp = 1'b1;
      endcase
    end

    // Register bus: one acknowledge per request, then a gap.
    if (wb_i.cyc && wb_i.stb && !st.wb_ack) begin
      next_st.wb_ack = 1'b1;
      next_st.wb_dat = '0;
      woff           = wb_i.adr;
      if (wb_i.we) begin
        case (woff)
          OFF_CTRL: begin
            if (wb_i.sel[0]) begin
              next_st.monitor = wb_i.dat[0];
            end
          end
          OFF_DBO: next_st.dbo = lane_merge(st.dbo, wb_i.dat, wb_i.sel);
          OFF_STATUS: begin
            // A flag raised in this same cycle survives the clear.
            if (wb_i.sel[0] && wb_i.dat[ST_XA_REFUSED] &&
                !(take && next_st.xa_refused && !st.xa_refused)) begin
              next_st.xa_refused = 1'b0;
            end
            if (wb_i.sel[0] && wb_i.dat[ST_UNSUPP] &&
                !(take && next_st.unsupp && !st.unsupp)) begin
              next_st.unsupp = 1'b0;
            end
          end
          default: next_st.wb_dat = '0;
        endcase
      end else begin
        case (woff)
          OFF_CTRL:   next_st.wb_dat = {31'h0, st.monitor};
          OFF_DBO:    next_st.wb_dat = st.dbo;
          OFF_XA:     next_st.wb_dat = st.xa;
          OFF_CLN:    next_st.wb_dat = st.cluster_number_register;
          OFF_VL:     next_st.wb_dat = st.vl;
          OFF_STATUS: begin
            next_st.wb_dat[ST_XA_REFUSED] = st.xa_refused;
            next_st.wb_dat[ST_UNSUPP]     = st.unsupp;
            next_st.wb_dat[ST_RSV_LO +: NREG] = st.rsv;
            next_st.wb_dat[ST_BUSY]       = |st.rsv;
          end
          default: begin
            if (woff[7:5] == OFF_AREG[7:5] && woff[1:0] == 2'h0) begin
              next_st.wb_dat = st.areg[woff[4:2]];
            end
          end
        endcase
      end
    end
  end

  // State register with constant reset values.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin : state_reg
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs are fields of the state register.
  assign wb_ack_o    = st.wb_ack;
  assign wb_dat_o    = st.wb_dat;
  assign issue_ack_o = st.issue_ack;
  assign mem_o       = st.mem;
  assign chan_sel_o  = st.chan_sel;
  assign s_result_o  = st.sres;
  assign jump_o      = st.jump;
  assign ipi_o       = st.ipi;
  assign xa_o        = st.xa;
  assign cln_o       = st.cluster_number_register;
  assign vl_o        = st.vl;

endmodule // arf_core

//--- sim/arf_core_props.sv
// Concurrent checks on the ports of the address register file core.
`timescale 1ns/10ps
module arf_core_props
  import arf_pkg::*;
(
  input wire logic         clk_sys_i,
  input wire logic         rst_i,
  input wire arf_wb_req_t  wb_i,
  input wire logic         wb_ack_o,
  input wire logic         issue_valid_i,
  input wire arf_instr_t   issue_instr_i,
  input wire logic         issue_ack_o,
  input wire arf_mem_req_t mem_o,
  input wire arf_sres_t    s_result_o,
  input wire arf_jump_t    jump_o,
  input wire arf_ipi_t     ipi_o,
  input wire logic [31:0]  xa_o,
  input wire logic [31:0]  vl_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  arf_instr_t p; // Instruction seen at the previous edge.
  // Keeps the instruction that an acknowledge refers to.
  always_ff @(posedge clk_sys_i) begin
    p <= issue_instr_i;
  end
  sequence s_req; wb_i.cyc && wb_i.stb && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_wb; s_req |=> s_ans; endproperty
  a_wb: assert property (p_wb) else $error("bus answer late");
  property p_ack;
    issue_ack_o |-> $past(issue_valid_i) && !$past(issue_ack_o);
  endproperty
  a_ack: assert property (p_ack) else $error("stray issue");
  property p_jump;
    jump_o.taken |-> issue_ack_o && p.g == 4'h1 && jump_o.target == p.imm;
  endproperty
  a_jump: assert property (p_jump) else $error("bad jump");
  property p_ipi;
    ipi_o.req |-> issue_ack_o && p.g == 4'h0 && p.h == 3'h1 && p.k == 3'h1;
  endproperty
  a_ipi: assert property (p_ipi) else $error("bad ipi");
  property p_ipi0; ipi_o.req && p.j == 3'h0 |-> ipi_o.cpu == 32'h0;
  endproperty
  a_ipi0: assert property (p_ipi0) else $error("bad zero j");
  property p_sres;
    s_result_o.vld |-> issue_ack_o && p.g == 4'h7 && s_result_o.idx == p.i;
  endproperty
  a_sres: assert property (p_sres) else $error("bad s move");
  property p_sk0; s_result_o.vld && p.j == 3'h0 && p.k == 3'h0
    |-> s_result_o.data == 64'h1; endproperty
  a_sk0: assert property (p_sk0) else $error("bad zero k");
  property p_mem; mem_o.req |-> issue_ack_o && p.g[3:1] == 3'h4
    && mem_o.we == (p.g == 4'h9); endproperty
  a_mem: assert property (p_mem) else $error("bad memory req");
  property p_xa; $changed(xa_o) |-> issue_ack_o && p.g == 4'h0
    && p.h == 3'h1 && p.i == 3'h3; endproperty
  a_xa: assert property (p_xa) else $error("bad xa change");
  property p_vl; $changed(vl_o) |-> issue_ack_o && p.g == 4'h0
    && p.h == 3'h2; endproperty
  a_vl: assert property (p_vl) else $error("bad vl change");
endmodule // arf_core_props
bind arf_core arf_core_props u_props (.clk_sys_i, .rst_i, .wb_i,
  .wb_ack_o, .issue_valid_i, .issue_instr_i, .issue_ack_o, .mem_o,
  .s_result_o, .jump_o, .ipi_o, .xa_o, .vl_o);

//--- sim/arf_partner.sv
// Model of the memory and channel side that faces the core.
`timescale 1ns/10ps
module arf_partner
  import arf_pkg::*;
#(
  parameter logic [31:0] KEY  = 32'h3c3c_a5a5, // Load data scramble.
  parameter logic [31:0] IRQN = 32'h0000_0005  // Top channel number.
)
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire arf_mem_req_t mem_i,
  input  wire logic [31:0]  sel_i,
  output logic [31:0]       rdata_o,
  output logic [31:0]       irq_o,
  output logic [31:0]       caddr_o,
  output logic              cerr_o
);
  logic [4:0][31:0] pa; // Load addresses in flight.
  logic [4:0]       pv; // Which stages hold a load.
  logic             tg; // Filler that changes every cycle.
  // Loads come back five edges after the request is seen.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pv <= '0;
      tg <= 1'b0;
    end else begin
      pv <= {pv[3:0], mem_i.req & ~mem_i.we};
      pa <= {pa[3:0], mem_i.addr};
      tg <= ~tg;
    end
  end
  assign rdata_o = pv[4] ? pa[4] ^ KEY : {32{tg}};
  assign irq_o = IRQN;
  assign caddr_o = sel_i ^ KEY;
  assign cerr_o = sel_i[0];
endmodule // arf_partner

//--- sim/test_address_register_file_issue.sv
// Self-checking bench for the address register file core.
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  err_count++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_address_register_file_issue;
  import arf_pkg::*;
  localparam logic [31:0] KEY = 32'h3c3c_a5a5;
  localparam logic [31:0] IRQN = 32'h0000_0005;
  logic         clk_sys_i = 1'b0, rst_i = 1'b1, iv = 1'b0;
  logic         wb_ack_o, issue_ack_o, cerr;
  arf_wb_req_t  wb = '0;
  arf_instr_t   ins = '0;
  logic [63:0]  sop = '0, s, sexp, sq[$];
  logic [31:0]  wb_dat_o, rdat, irq, caddr, d, m, a, b, e[8], q[$];
  logic [31:0]  xa_o, cln_o, vl_o, chan_sel_o, wexp, iq[$];
  arf_mem_req_t mem_o;
  arf_sres_t    sr;
  arf_jump_t    jmp;
  arf_ipi_t     ipi;
  logic [2:0]   i, j, k;
  logic [3:0]   jv = '0;
  int           seed = 32'h04dbc97a, err_count = 0, check_count = 0, op;
  always #5 clk_sys_i = ~clk_sys_i;
  arf_core DUT (.clk_sys_i, .rst_i, .wb_i(wb), .wb_ack_o, .wb_dat_o,
    .issue_valid_i(iv), .issue_instr_i(ins), .issue_s_op_i(sop),
    .issue_ack_o, .mem_o, .mem_rdata_i(rdat), .chan_irq_num_i(irq),
    .chan_addr_i(caddr), .chan_err_i(cerr), .chan_sel_o, .s_result_o(sr),
    .jump_o(jmp), .ipi_o(ipi), .xa_o, .cln_o, .vl_o);
  arf_partner #(.KEY(KEY), .IRQN(IRQN)) PM (.clk_sys_i, .rst_i,
    .mem_i(mem_o), .sel_i(chan_sel_o), .rdata_o(rdat), .irq_o(irq),
    .caddr_o(caddr), .cerr_o(cerr));
  // Takes the oldest note off a queue whenever a bus answer, scalar move or interrupt shows.
  always @(posedge clk_sys_i) begin
    if (wb_ack_o === 1'b1) begin
      wexp = q.pop_front();
      `CHK(wb_dat_o, wexp)
    end
    if (sr.vld === 1'b1) begin
      sexp = sq.pop_front();
      `CHK(sr.data, sexp)
    end
    if (ipi.req === 1'b1) begin
      wexp = iq.pop_front();
      `CHK(ipi.cpu, wexp)
    end
    if (jmp.taken === 1'b1) begin
      jv[ins.h[1:0]] = 1'b1;
      `CHK(jmp.target, m)
    end
    if (mem_o.req === 1'b1 && mem_o.we === 1'b1)
      `CHK({mem_o.addr, mem_o.wdata}, {d + e[4] + m, e[5]})
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang;
    err_count++;
    complete_run();
  endtask
  // One classic bus cycle; the expected read word is noted first.
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] dd, ex);
    int n;
    n = 0;
    q.push_back(ex);
    wb <= '{1'b1, 1'b1, w, 4'hf, ad, dd};
    do @(negedge clk_sys_i); while (wb_ack_o !== 1'b1 && ++n < 99);
    if (n >= 99) hang();
    @(posedge clk_sys_i);
    wb <= '0;
    @(posedge clk_sys_i);
  endtask
  // Offers one instruction and returns at the edge that sees it issued.
  task automatic iss(input logic [3:0] g, input logic [2:0] h, ii, jj, kk,
                     input logic [31:0] im, input logic [63:0] so);
    int n;
    n = 0;
    iv <= 1'b1;
    ins <= '{g, h, ii, jj, kk, im};
    sop <= so;
    do @(negedge clk_sys_i); while (issue_ack_o !== 1'b1 && ++n < 99);
    if (n >= 99) hang();
    @(posedge clk_sys_i);
  endtask
  task automatic idle(input int n);
    iv <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic rd_all;
    for (int r = 0; r < 8; r++) bus(1'b0, 8'(OFF_AREG + 4 * r), '0, e[r]);
    bus(1'b0, OFF_STATUS, '0, '0);
  endtask
  function automatic logic [31:0] lz(input logic [63:0] v);
    int n;
    n = 0;
    while (n < 64 && !v[63 - n]) n++;
    return 32'(n);
  endfunction
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    for (int r = 0; r < 8; r++) e[r] = '0;
    rd_all();
    // Random dependent chain, issued back to back.
    for (int t = 0; t < 60; t++) begin
      op = {$random(seed)} % 6;
      {i, j, k} = 9'($random(seed));
      m = $random(seed);
      a = (j == 3'h0) ? 32'h0 : e[j];
      b = (k == 3'h0) ? 32'h1 : e[k];
      iss(4'(2 + op / 3), 3'(op % 3), i, j, k, m, '0);
      case (op)
        0: e[i] = m;
        1: e[i] = ~m;
        2: e[i] = {26'h0, j, k};
        3: e[i] = a + b;
        4: e[i] = a - b;
        default: e[i] = a * b;
      endcase
    end
    idle(8);
    rd_all();
    for (int t = 0; t < 24; t++) begin
      j = 3'(t % 3);
      k = 3'(t / 3);
      b = (k == 3'h0) ? 32'h1 : e[k];
      sq.push_back(j == 0 ? {32'h0, b} : j == 1 ? {{32{b[31]}}, b}
                   : {1'b0, FP_EXP_UNRM, 16'h0, b});
      iss(4'h7, 3'h1, k, j, k, '0, '0);
    end
    for (int t = 0; t < 6; t++) begin
      s = {$random(seed), $random(seed)} >> (t * 9);
      op = t % 3;
      iss(4'h2, 3'(op / 2 + 6), 3'(t + 1), 3'h1, 3'(op % 2), '0, s);
      e[t + 1] = op == 0 ? 32'($countones(s)) : op == 1 ?
                 32'($countones(s) % 2) : lz(s);
    end
    idle(8);
    d = $random(seed);
    bus(1'b1, OFF_DBO, d, '0);
    e[7] = e[1] * e[2];
    e[5] = (d + e[4] + m) ^ KEY;
    e[6] = (d + m) ^ KEY;
    iss(4'h8, 3'h4, 3'h5, 3'h0, 3'h0, m, '0);
    iss(4'h3, 3'h2, 3'h7, 3'h1, 3'h2, '0, '0);
    iss(4'h8, 3'h0, 3'h6, 3'h0, 3'h0, m, '0);
    iss(4'h9, 3'h4, 3'h5, 3'h0, 3'h0, m, '0);
    idle(8);
    rd_all();
    iss(4'h0, 3'h1, 3'h3, 3'h1, 3'h0, '0, '0);
    idle(2);
    bus(1'b0, OFF_XA, '0, '0);
    bus(1'b0, OFF_STATUS, '0, 32'h1);
    bus(1'b1, OFF_STATUS, 32'h1, '0);
    bus(1'b1, OFF_CTRL, 32'h1, '0);
    bus(1'b0, 8'h1c, '0, '0);
    iss(4'h0, 3'h1, 3'h3, 3'h1, 3'h0, '0, '0);
    iss(4'h0, 3'h1, 3'h4, 3'h2, 3'h3, '0, '0);
    iss(4'h0, 3'h2, 3'h0, 3'h0, 3'h3, '0, '0);
    iq.push_back(e[6]);
    iq.push_back(32'h0);
    iss(4'h0, 3'h1, 3'h4, 3'h6, 3'h1, '0, '0);
    iss(4'h0, 3'h1, 3'h4, 3'h0, 3'h1, '0, '0);
    for (int h = 0; h < 4; h++) iss(4'h1, 3'(h), 3'h0, 3'h0, 3'h0, m, '0);
    iss(4'h2, 3'h3, 3'h6, 3'h1, 3'h0, '0, s);
    iss(4'h2, 3'h3, 3'h7, 3'h0, 3'h1, '0, '0);
    idle(4);
    `CHK(jv, {e[0][31], !e[0][31], e[0] != 32'h0, e[0] == 32'h0})
    `CHK({xa_o, cln_o, vl_o}, {e[1], e[2], e[3]})
    bus(1'b0, OFF_XA, '0, e[1]);
    bus(1'b0, OFF_CLN, '0, e[2]);
    bus(1'b0, OFF_VL, '0, e[3]);
    e[6] = s[31:0];
    e[7] = e[3];
    iss(4'h3, 3'h3, 3'h1, 3'h0, 3'h0, '0, '0);
    iss(4'h3, 3'h3, 3'h2, 3'h3, 3'h0, '0, '0);
    iss(4'h3, 3'h3, 3'h4, 3'h3, 3'h1, '0, '0);
    e[1] = IRQN;
    e[2] = e[3] ^ KEY;
    e[4] = {31'h0, e[3][0]};
    idle(8);
    rd_all();
    complete_run();
  end
endmodule // test_address_register_file_issue
